// [pkg/msrh_pkg.sv]
package msrh_pkg;
  localparam int NUM_CORES = 8;
  localparam int CORE_IDX_W = 3;
  localparam int PIN_W = 32;
  localparam int NUM_SEM = 8;
  // Hub window: every core once per 16 system clocks (hub runs at clk/2)
  localparam int HUB_DIV = 2;
  localparam int WINDOW_PERIOD = 16;
  localparam int HUB_OP_CYCLES = 7;
  localparam int HUB_MAX_WAIT = 15;
  localparam int HUB_MAX_TOTAL = 22;
  localparam int HUB_SPARE_CYCLES = 9;
  localparam int SLOT_CNT_W = 4;
  // Hub operation codes
  localparam logic [2:0] OP_SEM_ALLOC = 3'h0;
  localparam logic [2:0] OP_SEM_REL = 3'h1;
  localparam logic [2:0] OP_SEM_SET = 3'h2;
  localparam logic [2:0] OP_SEM_CLR = 3'h3;
  // Wishbone register map (byte addresses)
  localparam logic [7:0] REG_CORE_RUN = 8'h00;
  localparam logic [7:0] REG_CORE_BUSY = 8'h04;
  localparam logic [7:0] REG_COUNTER = 8'h08;
  localparam logic [7:0] REG_SEM_USED = 8'h0c;
  localparam logic [7:0] REG_SEM_VAL = 8'h10;
  localparam logic [7:0] REG_PIN_DIR = 8'h14;
  localparam logic [7:0] REG_PIN_OUT = 8'h18;
  localparam logic [7:0] REG_PIN_IN = 8'h1c;
  localparam logic [7:0] REG_SLOT = 8'h20;
  localparam logic [7:0] CORE_REG_BASE = 8'h40;
  localparam logic [31:0] RUN_RESET = 32'h0000_0001;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_EXEC = 3'b100
  } msrh_state_type;
endpackage

// [logic/msrh_hub.sv]
// The implementer's own choices: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
// Notes on behaviour
// - Eight identical cores 0-7, individually runnable.
// - All cores share one clock, run concurrently.
// - Grant rotates core 0 to 7, then wraps.
// - Hub at half clock, window every 16.
// - Hub op waits for window, takes 7.
// - Window wait 0-15, total 7-22 cycles.
// - Nine spare cycles follow each aligned access.
// - One core's access never stalls others.
// - Each core owns direction and output registers.
// - Pin direction is OR of all directions.
// - Output is OR of masked core contributions.
// - Direction bit one means output.
// - Stopped core contributes nothing to pins.
// - Input view returns live pin states.
// - Free 32-bit counter, read by all.
// - Counter is not cleared at reset.
// - Eight global lock semaphores.
// - Track allocated and value; four operations.
// - Semaphores change only inside a window.
module msrh_hub #(
  parameter int NUM_CORES = msrh_pkg::NUM_CORES,
  parameter int PIN_W = msrh_pkg::PIN_W
) (
  input wire logic clk_i,                       // System clock, 40 MHz
  input wire logic rst_i,                       // Synchronous reset
  input wire logic [31:0] wb_adr_i,             // Wishbone address
  input wire logic [31:0] wb_dat_i,             // Wishbone write data
  input wire logic [3:0] wb_sel_i,              // Wishbone byte selects
  input wire logic wb_we_i,                     // Wishbone write enable
  input wire logic wb_cyc_i,                    // Wishbone cycle
  input wire logic wb_stb_i,                    // Wishbone strobe
  output logic [31:0] wb_dat_o,                 // Wishbone read data
  output logic wb_ack_o,                        // Wishbone acknowledge
  input wire logic [NUM_CORES-1:0] hub_req_i,   // Per-core hub request
  input wire logic [3*NUM_CORES-1:0] hub_op_i,  // Per-core op code
  input wire logic [3*NUM_CORES-1:0] hub_sem_i, // Per-core lock index
  output logic [NUM_CORES-1:0] hub_done_o,      // Op complete pulse
  output logic [3:0] hub_res_o,                 // Result {fail,data}
  output logic [2:0] hub_core_o,                // Core now granted
  output logic [31:0] counter_o,                // System counter
  input wire logic [PIN_W-1:0] pin_in_i,        // Pin levels
  output logic [PIN_W-1:0] pin_out_o,           // Pin output values
  output logic [PIN_W-1:0] pin_oe_o             // Pin output enables
);
  ////////////////////////////////////////////////////////////////////////
  // System counter
  // No reset: software uses differences only; the start value is arbitrary
  logic [31:0] cnt_q = 32'h0000_0000;
  always_ff @(posedge clk_i)
  begin
    cnt_q <= cnt_q + 32'h0000_0001;
  end
  assign counter_o = cnt_q;

  ////////////////////////////////////////////////////////////////////////
  // Hub slot timing: 16 cycles, two per core
  logic [3:0] slot_q;
  logic [2:0] grant_core;
  logic window_start;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      slot_q <= 4'h0;
    else
      slot_q <= slot_q + 4'h1;
  end
  assign grant_core = slot_q[3:1];
  assign window_start = (slot_q[0] == 1'b0);
  assign hub_core_o = grant_core;

  ////////////////////////////////////////////////////////////////////////
  // Core run control and per-core I/O registers
  logic [NUM_CORES-1:0] run_q;
  logic [PIN_W-1:0] dir_q [NUM_CORES];
  logic [PIN_W-1:0] out_q [NUM_CORES];
  logic [PIN_W-1:0] contrib [NUM_CORES];
  logic [PIN_W-1:0] dir_eff [NUM_CORES];
  logic wb_req;
  logic wb_wr;
  logic [7:0] wb_off;
  logic core_sel;
  logic [2:0] core_idx;
  logic core_reg;
  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wb_wr = wb_req & wb_we_i;
  assign wb_off = wb_adr_i[7:0];
  assign core_sel = (wb_off >= msrh_pkg::CORE_REG_BASE) &&
                    (wb_off < 8'h80) && (wb_adr_i[31:8] == 24'h0);
  assign core_idx = wb_off[5:3];
  assign core_reg = wb_off[2];

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
      if (sel[b])
        r[8*b +: 8] = nw[8*b +: 8];
    return r;
  endfunction

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      run_q <= msrh_pkg::RUN_RESET[NUM_CORES-1:0];
    else if (wb_wr && wb_off == msrh_pkg::REG_CORE_RUN && wb_sel_i[0])
      run_q <= wb_dat_i[NUM_CORES-1:0];
  end

  genvar g;
  generate
    for (g = 0; g < NUM_CORES; g++)
    begin : g_core
      always_ff @(posedge clk_i)
      begin
        if (rst_i || !run_q[g])
        begin
          dir_q[g] <= '0;
          out_q[g] <= '0;
        end
        else if (wb_wr && core_sel && core_idx == 3'(g))
        begin
          if (!core_reg)
            dir_q[g] <= merge(dir_q[g], wb_dat_i, wb_sel_i);
          else
            out_q[g] <= merge(out_q[g], wb_dat_i, wb_sel_i);
        end
      end
      // Counter bits are outside this block; only out_q, masked by dir_eff, feeds contrib
      assign dir_eff[g] = run_q[g] ? dir_q[g] : '0;
      assign contrib[g] = out_q[g] & dir_eff[g];
    end
  endgenerate

  always_comb
  begin
    pin_oe_o = '0;
    pin_out_o = '0;
    for (int c = 0; c < NUM_CORES; c++)
    begin
      pin_oe_o = pin_oe_o | dir_eff[c];
      pin_out_o = pin_out_o | contrib[c];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Per-core hub sequencers: each core waits only for its own window
  msrh_pkg::msrh_state_type st_q [NUM_CORES];
  logic [2:0] exec_q [NUM_CORES];
  logic [2:0] op_q [NUM_CORES];
  logic [2:0] idx_q [NUM_CORES];
  logic [NUM_CORES-1:0] start;
  logic [NUM_CORES-1:0] busy;
  generate
    for (g = 0; g < NUM_CORES; g++)
    begin : g_seq
      assign start[g] = window_start && grant_core == 3'(g) &&
        ((st_q[g] == msrh_pkg::ST_WAIT) ||
         (st_q[g] == msrh_pkg::ST_IDLE && hub_req_i[g])) && run_q[g];
      assign busy[g] = st_q[g] != msrh_pkg::ST_IDLE;
      assign hub_done_o[g] = (st_q[g] == msrh_pkg::ST_EXEC) &&
                             (exec_q[g] == 3'(msrh_pkg::HUB_OP_CYCLES - 1));
      always_ff @(posedge clk_i)
      begin
        if (rst_i || !run_q[g])
        begin
          st_q[g] <= msrh_pkg::ST_IDLE;
          exec_q[g] <= 3'h0;
          op_q[g] <= 3'h0;
          idx_q[g] <= 3'h0;
        end
        else
        begin
          case (st_q[g])
            msrh_pkg::ST_IDLE:
            begin
              if (hub_req_i[g])
              begin
                op_q[g] <= hub_op_i[3*g +: 3];
                idx_q[g] <= hub_sem_i[3*g +: 3];
                st_q[g] <= start[g] ? msrh_pkg::ST_EXEC
                                    : msrh_pkg::ST_WAIT;
                exec_q[g] <= 3'h0;
              end
            end
            msrh_pkg::ST_WAIT:
            begin
              if (start[g])
                st_q[g] <= msrh_pkg::ST_EXEC;
            end
            msrh_pkg::ST_EXEC:
            begin
              if (hub_done_o[g])
                st_q[g] <= msrh_pkg::ST_IDLE;
              else
                exec_q[g] <= exec_q[g] + 3'h1;
            end
            default:
              st_q[g] <= msrh_pkg::ST_IDLE;
          endcase
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Lock semaphores: touched only by the core whose window starts
  logic [msrh_pkg::NUM_SEM-1:0] used_q;
  logic [msrh_pkg::NUM_SEM-1:0] val_q;
  logic [3:0] res_q;
  logic [2:0] gop;
  logic [2:0] gidx;
  logic gstart;
  logic [2:0] free_idx;
  logic any_free;
  assign gstart = start[grant_core];
  assign gop = (st_q[grant_core] == msrh_pkg::ST_IDLE) ?
               hub_op_i[3*grant_core +: 3] : op_q[grant_core];
  assign gidx = (st_q[grant_core] == msrh_pkg::ST_IDLE) ?
                hub_sem_i[3*grant_core +: 3] : idx_q[grant_core];
  always_comb
  begin
    free_idx = 3'h0;
    any_free = 1'b0;
    for (int s = msrh_pkg::NUM_SEM - 1; s >= 0; s--)
      if (!used_q[s])
      begin
        free_idx = 3'(s);
        any_free = 1'b1;
      end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      used_q <= '0;
      val_q <= '0;
      res_q <= 4'h0;
    end
    else if (gstart)
    begin
      case (gop)
        msrh_pkg::OP_SEM_ALLOC:
        begin
          if (any_free)
          begin
            used_q[free_idx] <= 1'b1;
            res_q <= {1'b0, free_idx};
          end
          else
            res_q <= 4'h8;
        end
        msrh_pkg::OP_SEM_REL:
        begin
          used_q[gidx] <= 1'b0;
          res_q <= 4'h0;
        end
        msrh_pkg::OP_SEM_SET:
        begin
          val_q[gidx] <= 1'b1;
          res_q <= {3'h0, val_q[gidx]};
        end
        msrh_pkg::OP_SEM_CLR:
        begin
          val_q[gidx] <= 1'b0;
          res_q <= {3'h0, val_q[gidx]};
        end
        default:
          res_q <= 4'h8;
      endcase
    end
  end
  assign hub_res_o = res_q;

  ////////////////////////////////////////////////////////////////////////
  // Wishbone slave, one wait state; unmapped reads return zero
  logic [31:0] rd_mux;
  logic [31:0] rd_q;
  logic ack_q;
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (core_sel)
      rd_mux = core_reg ? out_q[core_idx] : dir_q[core_idx];
    else if (wb_adr_i[31:8] == 24'h0)
      case (wb_off)
        msrh_pkg::REG_CORE_RUN: rd_mux = {24'h0, run_q};
        msrh_pkg::REG_CORE_BUSY: rd_mux = {24'h0, busy};
        msrh_pkg::REG_COUNTER: rd_mux = cnt_q;
        msrh_pkg::REG_SEM_USED: rd_mux = {24'h0, used_q};
        msrh_pkg::REG_SEM_VAL: rd_mux = {24'h0, val_q};
        msrh_pkg::REG_PIN_DIR: rd_mux = pin_oe_o;
        msrh_pkg::REG_PIN_OUT: rd_mux = pin_out_o;
        msrh_pkg::REG_PIN_IN: rd_mux = pin_in_i;
        msrh_pkg::REG_SLOT: rd_mux = {28'h0, slot_q};
        default: rd_mux = 32'h0000_0000;
      endcase
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q <= 1'b0;
      rd_q <= 32'h0000_0000;
    end
    else
    begin
      ack_q <= wb_req;
      rd_q <= rd_mux;
    end
  end
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rd_q;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  logic [4:0] wait_cnt [NUM_CORES];
  generate
    for (g = 0; g < NUM_CORES; g++)
    begin : g_wc
      always_ff @(posedge clk_i)
      begin
        if (rst_i || st_q[g] != msrh_pkg::ST_WAIT)
          wait_cnt[g] <= 5'h0;
        else
          wait_cnt[g] <= wait_cnt[g] + 5'h1;
      end
    end
  endgenerate

  sequence s_exec_run;
    st_q[0] == msrh_pkg::ST_EXEC [*6];
  endsequence

  chk_exec_len: assert property (@(posedge clk_i) disable iff (rst_i)
    (start[0] && run_q[0]) ##1 (s_exec_run and run_q[0] [*6])
      |=> hub_done_o[0])
    else $error("hub op not seven cycles");
  chk_wait_bound: assert property (@(posedge clk_i) disable iff (rst_i)
    wait_cnt[0] <= 5'(msrh_pkg::HUB_MAX_WAIT))
    else $error("window wait above limit");
  chk_rotation: assert property (@(posedge clk_i) disable iff (rst_i)
    window_start |-> ##2 (grant_core == $past(grant_core, 2) + 3'h1))
    else $error("grant not rotating");
  chk_window_only: assert property (@(posedge clk_i) disable iff (rst_i)
    (used_q != $past(used_q)) |-> $past(gstart))
    else $error("lock changed outside window");
  chk_counter_inc: assert property (@(posedge clk_i) disable iff (rst_i)
    counter_o == $past(counter_o) + 32'h0000_0001)
    else $error("counter did not step");
  chk_pin_dir: assert property (@(posedge clk_i) disable iff (rst_i)
    !run_q[0] |-> (dir_eff[0] == '0 && contrib[0] == '0))
    else $error("stopped core drives pins");
  chk_pin_mask: assert property (@(posedge clk_i) disable iff (rst_i)
    ((pin_out_o & ~pin_oe_o) == '0))
    else $error("output without direction");
  chk_set_prev: assert property (@(posedge clk_i) disable iff (rst_i)
    (gstart && gop == msrh_pkg::OP_SEM_SET) |=>
      (hub_res_o[0] == $past(val_q[gidx]) && val_q[$past(gidx)]))
    else $error("set result wrong");
  chk_alloc_full: assert property (@(posedge clk_i) disable iff (rst_i)
    (gstart && gop == msrh_pkg::OP_SEM_ALLOC && &used_q) |=>
      hub_res_o[3])
    else $error("full alloc not failed");
  chk_core_indep: assert property (@(posedge clk_i) disable iff (rst_i)
    (start[1] && run_q[1]) |=> st_q[1] == msrh_pkg::ST_EXEC)
    else $error("core start blocked");
endmodule

// [testbench/msrh_core_model.sv]
`timescale 1ns/1ps
module msrh_core_model (
  input wire logic clk_i,         // System clock
  input wire logic rst_i,         // Sync reset
  input wire logic [7:0] go_i,    // Start pulse per core
  input wire logic [23:0] op_i,   // Op code per core
  input wire logic [23:0] sem_i,  // Lock index per core
  input wire logic [7:0] done_i,  // Completion from hub
  output logic [7:0] req_o,       // Request level per core
  output logic [23:0] op_o,       // Op code to hub
  output logic [23:0] sem_o       // Lock index to hub
);
  logic [7:0] pend_q;
  logic [23:0] op_q;
  logic [23:0] sem_q;
  // A core waits for its window; the request is never withdrawn early
  assign req_o = pend_q | go_i;
  // With no core pending or starting, all codes show inverted so stale values cannot be trusted
  assign op_o = (go_i != 8'h0) ? op_i : ((pend_q != 8'h0) ? op_q : ~op_q);
  assign sem_o = (go_i != 8'h0) ? sem_i : ((pend_q != 8'h0) ? sem_q : ~sem_q);
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pend_q <= 8'h0;
    else
      pend_q <= (pend_q | go_i) & ~done_i;
    if (go_i != 8'h0)
    begin
      op_q <= op_i;
      sem_q <= sem_i;
    end
  end
endmodule

// [testbench/testbench.sv]
`timescale 1ns/1ps
module testbench;
  logic clk_i, rst_i, we, cyc, stb, ack;
  logic [31:0] adr, dat, dat_o, pin_in, pin_out, pin_oe, cnt;
  logic [3:0] res;
  logic [2:0] core;
  logic [7:0] go, req, done;
  logic [23:0] op, sem, hop, hsem;
  int failures, compares;

  msrh_hub uut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr),
    .wb_dat_i(dat), .wb_sel_i(4'hf), .wb_we_i(we), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_dat_o(dat_o), .wb_ack_o(ack), .hub_req_i(req),
    .hub_op_i(hop), .hub_sem_i(hsem), .hub_done_o(done), .hub_res_o(res),
    .hub_core_o(core), .counter_o(cnt), .pin_in_i(pin_in),
    .pin_out_o(pin_out), .pin_oe_o(pin_oe));
  msrh_core_model model (.clk_i(clk_i), .rst_i(rst_i), .go_i(go),
    .op_i(op), .sem_i(sem), .done_i(done), .req_o(req), .op_o(hop),
    .sem_o(hsem));

  ////////////////////////////////////////////////////////////////////////
  task check(input string name, input logic [31:0] seen,
    input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task complete_run;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task wb(input logic [7:0] a, input logic w, input logic [31:0] d,
    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    adr <= {24'h0, a};
    dat <= d;
    we <= w;
    cyc <= 1'b1;
    stb <= 1'b1;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack !== 1'b1);
    // The slave registers its answer: ack is seen at the second edge
    check("bus latency", n, 2);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task hub_op(input int c, input logic [2:0] o, input logic [2:0] s,
    output int n, output logic [3:0] r);
    @(posedge clk_i);
    go <= 8'h1 << c;
    op <= {8{o}};
    sem <= {8{s}};
    n = 0;
    do
    begin
      @(posedge clk_i);
      go <= 8'h0;
      n++;
      #1;
    end
    while (done[c] !== 1'b1 && n < 40);
    r = res;
  endtask

  ////////////////////////////////////////////////////////////////////////
  task test_rotation;
    logic [2:0] prev;
    int chg;
    chg = 0;
    @(posedge clk_i);
    #1;
    prev = core;
    repeat (32)
    begin
      @(posedge clk_i);
      #1;
      if (core !== prev)
      begin
        chg++;
        check("slot step", core, 3'(prev + 3'h1));
      end
      prev = core;
    end
    check("slot changes", chg, 16);
    $display("test rotation done");
  endtask

  task test_latency;
    int n, off;
    logic [3:0] r;
    // One aligning run first, so every later run starts at a known phase
    hub_op(0, msrh_pkg::OP_SEM_CLR, 3'h7, n, r);
    check("latency range", (n >= 7) && (n <= 22), 1'b1);
    for (off = 0; off < 16; off++)
    begin
      repeat (off) @(posedge clk_i);
      hub_op(0, msrh_pkg::OP_SEM_CLR, 3'h7, n, r);
      // Each run ends at the same slot phase, so the offset fixes the wait
      check("latency", n, (off <= 8) ? 15 - off : 31 - off);
    end
    $display("test latency done");
  endtask

  task test_pins;
    logic [31:0] q, eo, eu;
    int c, k, sk;
    for (c = 0; c < 8; c++)
    begin
      wb(msrh_pkg::CORE_REG_BASE + 8'(8 * c), 1'b1, 32'h3 << (4 * c), q);
      wb(msrh_pkg::CORE_REG_BASE + 8'(8 * c + 4), 1'b1, 32'h5 << (4 * c), q);
    end
    for (k = 0; k < 2; k++)
    begin
      sk = (k == 1) ? 3 : 8;
      if (k == 1)
        wb(msrh_pkg::REG_CORE_RUN, 1'b1, 32'hf7, q);
      eo = 32'h0;
      eu = 32'h0;
      for (c = 0; c < 8; c++)
        if (c != sk)
        begin
          eo |= 32'h3 << (4 * c);
          eu |= 32'h1 << (4 * c);
        end
      #1;
      check("pin enables", pin_oe, eo);
      check("pin outputs", pin_out, eu);
      wb(msrh_pkg::REG_PIN_DIR, 1'b0, 32'h0, q);
      check("pin dir view", q, eo);
    end
    wb(8'h58, 1'b0, 32'h0, q);
    check("stopped core dir", q, 32'h0);
    wb(msrh_pkg::REG_CORE_RUN, 1'b1, 32'hff, q);
    pin_in <= 32'ha5c3_0f96;
    wb(msrh_pkg::REG_PIN_IN, 1'b0, 32'h0, q);
    check("pin input view", q, 32'ha5c3_0f96);
    $display("test pins done");
  endtask

  task test_sems;
    logic [31:0] q;
    logic [7:0] m;
    logic [3:0] r;
    int n;
    m = 8'h0;
    @(posedge clk_i);
    go <= 8'hff;
    op <= {8{msrh_pkg::OP_SEM_ALLOC}};
    sem <= 24'h0;
    repeat (24)
    begin
      @(posedge clk_i);
      go <= 8'h0;
      #1;
      m |= done;
    end
    check("all cores served", m, 8'hff);
    wb(msrh_pkg::REG_SEM_USED, 1'b0, 32'h0, q);
    check("locks used", q, 32'hff);
    hub_op(5, msrh_pkg::OP_SEM_ALLOC, 3'h0, n, r);
    check("alloc when full", r, 4'h8);
    hub_op(2, msrh_pkg::OP_SEM_SET, 3'h4, n, r);
    check("set prev clear", r, 4'h0);
    wb(msrh_pkg::REG_SEM_VAL, 1'b0, 32'h0, q);
    check("lock values set", q, 32'h10);
    hub_op(2, msrh_pkg::OP_SEM_SET, 3'h4, n, r);
    check("set prev set", r, 4'h1);
    hub_op(2, msrh_pkg::OP_SEM_CLR, 3'h4, n, r);
    check("clear prev set", r, 4'h1);
    wb(msrh_pkg::REG_SEM_VAL, 1'b0, 32'h0, q);
    check("lock values clear", q, 32'h0);
    hub_op(2, msrh_pkg::OP_SEM_REL, 3'h3, n, r);
    hub_op(6, msrh_pkg::OP_SEM_ALLOC, 3'h0, n, r);
    check("alloc freed index", r, 4'h3);
    $display("test locks done");
  endtask

  task test_counter;
    logic [31:0] q, q2, c0;
    @(posedge clk_i);
    #1;
    c0 = cnt;
    repeat (10) @(posedge clk_i);
    #1;
    check("counter step", cnt - c0, 32'h0000_000a);
    // Two back-to-back reads are taken three edges apart
    wb(msrh_pkg::REG_COUNTER, 1'b0, 32'h0, q);
    wb(msrh_pkg::REG_COUNTER, 1'b0, 32'h0, q2);
    check("counter bus step", q2 - q, 32'h0000_0003);
    $display("test counter done");
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  initial
  begin
    #1000000;
    $display("watchdog expired");
    failures++;
    complete_run;
  end

  initial
  begin : main
    logic [31:0] q;
    failures = 0;
    compares = 0;
    rst_i = 1'b1;
    {we, cyc, stb} = 3'h0;
    adr = 32'h0;
    dat = 32'h0;
    go = 8'h0;
    op = 24'h0;
    sem = 24'h0;
    pin_in = 32'h0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(msrh_pkg::REG_CORE_RUN, 1'b0, 32'h0, q);
    check("run after reset", q, msrh_pkg::RUN_RESET);
    wb(8'h3c, 1'b0, 32'h0, q);
    check("unmapped read", q, 32'h0);
    wb(msrh_pkg::REG_CORE_RUN, 1'b1, 32'hff, q);
    test_rotation;
    test_latency;
    test_pins;
    test_sems;
    test_counter;
    complete_run;
  end
endmodule
